// *** rtl/ascx_pkg.sv ***
// Purpose: constants for the async serial channel
// Assumes: plain register port, 4-bit register index
// Notes:   bit positions follow the control register layouts
package ascx_pkg;
    // register indices
    localparam logic [3:0] REG_RX_CTRL   = 4'h3;
    localparam logic [3:0] REG_MODE      = 4'h4;
    localparam logic [3:0] REG_TX_CTRL   = 4'h5;
    localparam logic [3:0] REG_SYNC_ADR  = 4'h6;
    localparam logic [3:0] REG_SYNC_FLG  = 4'h7;
    localparam logic [3:0] REG_TX_DATA   = 4'h8;
    localparam logic [3:0] REG_MISC      = 4'hA;
    localparam logic [3:0] REG_EXT_STAT  = 4'hF;
    localparam logic [3:0] REG_LINE_STAT = 4'h0;
    localparam logic [3:0] REG_SPEC_STAT = 4'h1;
    localparam logic [3:0] REG_RX_DATA   = 4'h9;
    localparam logic [3:0] REG_FLAG_EXT  = 4'hE;
    // mode_param_reg fields
    localparam int MODE_PAR_EN   = 0;
    localparam int MODE_PAR_EVEN = 1;
    localparam int MODE_STOP_LO  = 2;
    localparam int MODE_STOP_HI  = 3;
    localparam int MODE_SYNC_LO  = 4;
    localparam int MODE_SYNC_HI  = 5;
    localparam int MODE_CLK_LO   = 6;
    localparam int MODE_CLK_HI   = 7;
    // rx_control_reg fields
    localparam int RXC_EN        = 0;
    localparam int RXC_AUTO      = 5;
    localparam int RXC_LEN_LO    = 6;
    localparam int RXC_LEN_HI    = 7;
    // tx_control_reg fields
    localparam int TXC_REQ       = 1;
    localparam int TXC_EN        = 3;
    localparam int TXC_BRK       = 4;
    localparam int TXC_LEN_LO    = 5;
    localparam int TXC_LEN_HI    = 6;
    // misc / ext / flag-ext fields
    localparam int MISC_D2       = 2;
    localparam int MISC_D3       = 3;
    localparam int EXT_AUTO_REL  = 0;
    localparam int FEX_AUTO_REL  = 2;
    // line_status_reg fields
    localparam int LS_RX_AVAIL   = 0;
    localparam int LS_TX_EMPTY   = 2;
    localparam int LS_CTS        = 5;
    localparam int LS_BREAK      = 7;
    // special_rx_status_reg fields
    localparam int SS_ALL_SENT   = 0;
    localparam int SS_PAR_ERR    = 4;
    localparam int SS_FRM_ERR    = 6;
    // stop selection codes
    localparam logic [1:0] STOP_ONE  = 2'h1;
    localparam logic [1:0] STOP_HALF = 2'h2;
    localparam logic [1:0] STOP_TWO  = 2'h3;
    // sync-mode code meaning bit-oriented synchronous operation
    localparam logic [1:0] SYNC_BITOR = 2'h2;
    // reset values
    localparam logic [7:0] MODE_RST  = 8'h04;
    localparam logic [7:0] ZERO8     = 8'h00;
endpackage

// *** rtl/ascx_channel.sv ***
// Purpose: one async serial channel, transmitter and receiver
// Assumes: TRXC_EN is a one-cycle tick per transmit/receive clock edge
// Notes:   one-deep receive holding register pairs data with its status
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module ascx_channel #(
    parameter int DW = 8
) (
    // clock and reset
    input  wire logic          CORE_CLK,
    input  wire logic          NRST,
    input  wire logic          CLK_EN,
    // bit clock tick
    input  wire logic          TRXC_EN,
    // register port
    input  wire logic [3:0]    REG_ADDR,
    input  wire logic [DW-1:0] REG_WDATA,
    input  wire logic          REG_WR,
    input  wire logic          REG_RD,
    output logic      [DW-1:0] REG_RDATA,
    // serial line
    input  wire logic          RXD,
    output logic               TXD,
    input  wire logic          CTS_N,
    output logic               RTS_N,
    // bit-oriented closing flag marker
    input  wire logic          FLAG_LAST_ZERO
);
    logic rst_s1_q, rst_n_q;
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    function automatic logic [6:0] factor_of(input logic [1:0] code, input logic sync);
        if (sync) begin
            factor_of = 7'h01;
        end else begin
            unique case (code)
                2'h0:    factor_of = 7'h01;
                2'h1:    factor_of = 7'h10;
                2'h2:    factor_of = 7'h20;
                default: factor_of = 7'h40;
            endcase
        end
    endfunction

    function automatic logic [3:0] bits_of(input logic [1:0] code);
        unique case (code)
            2'h0:    bits_of = 4'h5;
            2'h1:    bits_of = 4'h7;
            2'h2:    bits_of = 4'h6;
            default: bits_of = 4'h8;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] rxc_q, mode_q, txc_q, misc_q, ext_q, fex_q, sadr_q, sflg_q;
    logic [7:0] txbuf_q;
    logic       txfull_q;
    logic       we;
    assign we = REG_WR && CLK_EN;
    always_ff @(posedge CORE_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rxc_q  <= ascx_pkg::ZERO8;
            mode_q <= ascx_pkg::MODE_RST;
            txc_q  <= ascx_pkg::ZERO8;
            misc_q <= ascx_pkg::ZERO8;
            ext_q  <= ascx_pkg::ZERO8;
            fex_q  <= ascx_pkg::ZERO8;
            sadr_q <= ascx_pkg::ZERO8;
            sflg_q <= ascx_pkg::ZERO8;
        end else if (we) begin
            unique case (REG_ADDR)
                ascx_pkg::REG_RX_CTRL:  rxc_q  <= REG_WDATA;
                ascx_pkg::REG_MODE:     mode_q <= REG_WDATA;
                ascx_pkg::REG_TX_CTRL:  txc_q  <= REG_WDATA;
                ascx_pkg::REG_MISC:     misc_q <= REG_WDATA;
                ascx_pkg::REG_EXT_STAT: ext_q  <= REG_WDATA;
                ascx_pkg::REG_FLAG_EXT: fex_q  <= REG_WDATA;
                ascx_pkg::REG_SYNC_ADR: sadr_q <= REG_WDATA;
                ascx_pkg::REG_SYNC_FLG: sflg_q <= REG_WDATA;
                default: ;
            endcase
        end
    end

    logic is_async, is_bitor, par_en, par_even, tx_go, brk;
    logic [6:0] factor;
    assign is_async = mode_q[ascx_pkg::MODE_STOP_HI:ascx_pkg::MODE_STOP_LO] != 2'h0;
    assign is_bitor = !is_async
                      && mode_q[ascx_pkg::MODE_SYNC_HI:ascx_pkg::MODE_SYNC_LO] == ascx_pkg::SYNC_BITOR;
    assign par_en   = mode_q[ascx_pkg::MODE_PAR_EN];
    assign par_even = mode_q[ascx_pkg::MODE_PAR_EVEN];
    assign factor   = factor_of(mode_q[ascx_pkg::MODE_CLK_HI:ascx_pkg::MODE_CLK_LO], !is_async);
    assign brk      = txc_q[ascx_pkg::TXC_BRK];
    assign tx_go    = txc_q[ascx_pkg::TXC_EN]
                      && !(rxc_q[ascx_pkg::RXC_AUTO] && CTS_N);

    ////////////////////////////////////////////////////////////////////////
    // transmitter, ticks counted in whole-bit cells; 1.5 stop is sent as two stop bits
    logic [6:0]  tdiv_q;
    logic        tcell;
    logic [11:0] tsh_q;
    logic [4:0]  tleft_q;
    logic        tbusy_q, txd_q, brk_act_q, sent_q, tdrain_q;
    logic [3:0]  tlen;
    logic [7:0]  tdat;
    logic        tpar;
    logic [1:0]  tstop;
    assign tcell = TRXC_EN && (tdiv_q == factor - 7'h01 || factor == 7'h01);
    always_ff @(posedge CORE_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tdiv_q <= 7'h00;
        end else if (CLK_EN && TRXC_EN) begin
            tdiv_q <= tcell ? 7'h00 : tdiv_q + 7'h01;
        end
    end

    always_comb begin
        tlen = bits_of(txc_q[ascx_pkg::TXC_LEN_HI:ascx_pkg::TXC_LEN_LO]);
        tdat = txbuf_q;
        if (tlen == 4'h5) begin
            // short characters use a leading-ones marker above the data
            if (txbuf_q[7:1] == 7'h78) tlen = 4'h1;
            else if (txbuf_q[7:2] == 6'h38) tlen = 4'h2;
            else if (txbuf_q[7:3] == 5'h18) tlen = 4'h3;
            else if (txbuf_q[7:4] == 4'h8) tlen = 4'h4;
        end
        for (int i = 0; i < 8; i++) begin
            if (i >= int'(tlen)) tdat[i] = 1'b0;
        end
        tpar  = ^tdat ^ !par_even;
        tstop = mode_q[ascx_pkg::MODE_STOP_HI:ascx_pkg::MODE_STOP_LO];
        if (tstop == ascx_pkg::STOP_HALF && factor == 7'h01) tstop = ascx_pkg::STOP_TWO;
    end

    always_ff @(posedge CORE_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tsh_q     <= 12'hFFF;
            tleft_q   <= 5'h00;
            tbusy_q   <= 1'b0;
            txd_q     <= 1'b1;
            brk_act_q <= 1'b0;
            sent_q    <= 1'b1;
            tdrain_q  <= 1'b0;
        end else if (CLK_EN) begin
            if (tcell) brk_act_q <= brk;
            if (tcell && !brk_act_q && is_async) begin
                tdrain_q <= tbusy_q && tleft_q == 5'h01;
                if (tbusy_q) begin
                    txd_q <= tsh_q[0];
                    tsh_q <= {1'b1, tsh_q[11:1]};
                    tleft_q <= tleft_q - 5'h01;
                    if (tleft_q == 5'h01) begin
                        tbusy_q <= 1'b0;
                        sent_q  <= !txfull_q;
                    end
                end else if (txfull_q && tx_go) begin
                    // frame: start, data, parity, stops
                    tsh_q <= {12'hFFF} & ({3'h7, tdat, 1'b0} | (12'hFFF << (int'(tlen) + 1)));
                    if (par_en) tsh_q[tlen + 4'h1] <= tpar;
                    tleft_q <= 5'(tlen) + 5'(par_en) + 5'(tstop == ascx_pkg::STOP_ONE ? 2'h2 : 2'h3);
                    tbusy_q <= 1'b1;
                    sent_q  <= 1'b0;
                    txd_q   <= 1'b1;
                end else begin
                    txd_q <= 1'b1;
                end
            end
        end
    end
    assign TXD = brk_act_q ? 1'b0 : txd_q;

    // buffer holds one character; load happens at frame start
    logic tload;
    assign tload = tcell && !brk_act_q && is_async && !tbusy_q && txfull_q && tx_go;
    always_ff @(posedge CORE_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            txbuf_q  <= ascx_pkg::ZERO8;
            txfull_q <= 1'b0;
        end else if (CLK_EN) begin
            if (we && REG_ADDR == ascx_pkg::REG_TX_DATA) begin
                txbuf_q  <= REG_WDATA;
                txfull_q <= 1'b1;
            end else if (tload) begin
                txfull_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // send-request pin
    logic req_hold_q, auto_rel;
    assign auto_rel = is_bitor && ext_q[ascx_pkg::EXT_AUTO_REL] && fex_q[ascx_pkg::FEX_AUTO_REL]
                      && misc_q[ascx_pkg::MISC_D3] && !misc_q[ascx_pkg::MISC_D2];
    always_ff @(posedge CORE_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            req_hold_q <= 1'b0;
        end else if (CLK_EN) begin
            if (txc_q[ascx_pkg::TXC_REQ]) req_hold_q <= 1'b1;
            else if (!auto_rel || FLAG_LAST_ZERO) req_hold_q <= 1'b0;
        end
    end
    logic req_act;
    always_comb begin
        req_act = txc_q[ascx_pkg::TXC_REQ];
        if (is_async && rxc_q[ascx_pkg::RXC_AUTO] && (tbusy_q || txfull_q || tdrain_q)) req_act = 1'b1;
        if (auto_rel && req_hold_q) req_act = 1'b1;
    end
    assign RTS_N = !req_act;

    ////////////////////////////////////////////////////////////////////////
    // receiver
    typedef enum logic [1:0] {R_IDLE, R_START, R_DATA, R_XHALF} ascx_rx_e;
    ascx_rx_e    rst_q;
    logic [6:0]  rdiv_q;
    logic [3:0]  rcnt_q;
    logic [8:0]  rsh_q;
    logic [2:0]  rdly_q;
    logic        rxd_prev_q, rx_en;
    logic [3:0]  rlen, rtot;
    logic [7:0]  rxdat_q;
    logic        rxavail_q, rpe_q, rfe_q, brk_q;
    logic [6:0]  rhalf;
    logic        rsamp;
    assign rx_en = rxc_q[ascx_pkg::RXC_EN];
    assign rlen  = bits_of(rxc_q[ascx_pkg::RXC_LEN_HI:ascx_pkg::RXC_LEN_LO]);
    assign rtot  = rlen + 4'(par_en);
    assign rhalf = factor == 7'h01 ? 7'h01 : {1'b0, factor[6:1]};
    assign rsamp = (rlen >= 4'h7) ? rdly_q[2] : RXD;
    always_ff @(posedge CORE_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdly_q <= 3'h7;
        end else if (CLK_EN && TRXC_EN) begin
            rdly_q <= {rdly_q[1:0], RXD};
        end
    end

    logic [7:0] rchar;
    logic       rpar_bad;
    always_comb begin
        rchar = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (i < int'(rtot) && i < 8) rchar[i] = rsh_q[9 - int'(rtot) + i];
        end
        rpar_bad = par_en && ((^(rsh_q >> (9 - int'(rtot)))) != !par_even);
    end

    logic rdone;
    assign rdone = CLK_EN && TRXC_EN && rst_q == R_DATA && rdiv_q >= factor && rcnt_q == rtot;
    always_ff @(posedge CORE_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rst_q <= R_IDLE;
            rdiv_q <= 7'h00;
            rcnt_q <= 4'h0;
            rsh_q <= 9'h000;
            rxd_prev_q <= 1'b1;
        end else if (CLK_EN && TRXC_EN) begin
            rxd_prev_q <= rsamp;
            rdiv_q <= rdiv_q + 7'h01;
            unique case (rst_q)
                R_IDLE: if (rx_en && is_async && rxd_prev_q && !rsamp) begin
                    rst_q <= R_START;
                    rdiv_q <= 7'h01;
                end
                R_START: if (rdiv_q >= rhalf) begin
                    rdiv_q <= 7'h01;
                    rcnt_q <= 4'h0;
                    rst_q <= rsamp ? R_IDLE : R_DATA;
                end
                R_DATA: if (rdiv_q >= factor) begin
                    rdiv_q <= 7'h01;
                    if (rcnt_q == rtot) begin
                        // stop sample
                        rst_q <= rsamp ? R_IDLE : R_XHALF;
                    end else begin
                        rsh_q <= {rsamp, rsh_q[8:1]};
                        rcnt_q <= rcnt_q + 4'h1;
                    end
                end
                R_XHALF: if (rdiv_q >= rhalf) rst_q <= R_IDLE;
            endcase
        end
    end

    logic fe_now, null_now;
    assign fe_now   = rdone && !rsamp;
    assign null_now = fe_now && rchar == 8'h00;
    always_ff @(posedge CORE_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            brk_q <= 1'b0;
        end else if (CLK_EN) begin
            if (null_now) brk_q <= 1'b1;
            else if (brk_q && TRXC_EN && rsamp) brk_q <= 1'b0;
        end
    end

    logic rd_data;
    assign rd_data = REG_RD && CLK_EN && REG_ADDR == ascx_pkg::REG_RX_DATA;
    always_ff @(posedge CORE_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rxdat_q <= ascx_pkg::ZERO8;
            rxavail_q <= 1'b0;
            rpe_q <= 1'b0;
            rfe_q <= 1'b0;
        end else if (CLK_EN) begin
            if (rdone && !(brk_q && rchar == 8'h00)) begin
                rxdat_q <= rchar;
                rxavail_q <= 1'b1; // new character wins over read
                rpe_q <= rpar_bad;
                rfe_q <= fe_now && !null_now;
            end else if (rd_data) begin
                rxavail_q <= 1'b0;
                rfe_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CORE_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            REG_RDATA <= ascx_pkg::ZERO8;
        end else if (CLK_EN) begin
            REG_RDATA <= ascx_pkg::ZERO8;
            if (REG_RD) begin
                unique case (REG_ADDR)
                    ascx_pkg::REG_LINE_STAT: begin
                        REG_RDATA[ascx_pkg::LS_RX_AVAIL] <= rxavail_q;
                        REG_RDATA[ascx_pkg::LS_TX_EMPTY] <= !txfull_q;
                        REG_RDATA[ascx_pkg::LS_CTS]      <= !CTS_N;
                        REG_RDATA[ascx_pkg::LS_BREAK]    <= brk_q;
                    end
                    ascx_pkg::REG_SPEC_STAT: begin
                        REG_RDATA[ascx_pkg::SS_ALL_SENT] <= sent_q && !txfull_q;
                        REG_RDATA[ascx_pkg::SS_PAR_ERR]  <= rpe_q;
                        REG_RDATA[ascx_pkg::SS_FRM_ERR]  <= rfe_q;
                    end
                    ascx_pkg::REG_RX_DATA:  REG_RDATA <= rxdat_q;
                    ascx_pkg::REG_RX_CTRL:  REG_RDATA <= rxc_q;
                    ascx_pkg::REG_MODE:     REG_RDATA <= mode_q;
                    ascx_pkg::REG_TX_CTRL:  REG_RDATA <= txc_q;
                    ascx_pkg::REG_MISC:     REG_RDATA <= misc_q;
                    ascx_pkg::REG_EXT_STAT: REG_RDATA <= ext_q;
                    ascx_pkg::REG_FLAG_EXT: REG_RDATA <= fex_q;
                    default: ;
                endcase
            end
        end
    end
endmodule

// *** bench/ascx_line_model.sv ***
// Purpose: serial line partner, bit tick source, frame sender and catcher
// Assumes: x16 factor, tick every second core clock, so 32 core clocks a bit
// Notes:   idle line is marking high
`timescale 1ns/1ps
module ascx_line_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // serial line
    output logic      tick,
    output logic      rxd,
    input  wire logic txd
);
    initial rxd = 1'b1;

    // local rate generator runs free, as a modem baud clock does
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick <= 1'b0;
        end else begin
            tick <= !tick;
        end
    end

    // lsb first, each bit held one full cell
    task automatic send_frame(input logic [15:0] b, input int n, input logic idle);
        @(posedge clk);
        for (int i = 0; i < n; i++) begin
            rxd <= b[i];
            repeat (32) @(posedge clk);
        end
        rxd <= idle;
    endtask

    // mid-cell sampling from the falling start edge
    task automatic get_frame(input int n, output logic [15:0] b);
        int k;
        k = 0;
        b = 16'h0000;
        while (txd !== 1'b0 && k < 4000) begin
            @(negedge clk);
            k++;
        end
        if (k >= 4000) begin
            b = 16'hXXXX;
        end else begin
            repeat (16) @(negedge clk);
            for (int i = 0; i < n; i++) begin
                b[i] = txd;
                repeat (32) @(negedge clk);
            end
        end
    endtask
endmodule

// *** bench/ascx_channel_monitor.sv ***
// Purpose: port checks for the async serial channel
// Assumes: control bits shadowed from writes on the register port
// Notes:   attached by bind
`timescale 1ns/1ps
module ascx_channel_monitor #(
    parameter int DW = 8
) (
    // clock and reset
    input wire logic          CORE_CLK,
    input wire logic          NRST,
    input wire logic          CLK_EN,
    input wire logic          TRXC_EN,
    // register port
    input wire logic [3:0]    REG_ADDR,
    input wire logic [DW-1:0] REG_WDATA,
    input wire logic          REG_WR,
    input wire logic          REG_RD,
    input wire logic [DW-1:0] REG_RDATA,
    // serial line
    input wire logic          RXD,
    input wire logic          TXD,
    input wire logic          CTS_N,
    input wire logic          RTS_N,
    input wire logic          FLAG_LAST_ZERO
);
    logic [DW-1:0] txc_q;
    logic [DW-1:0] rxc_q;
    logic [DW-1:0] mode_q;

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            txc_q <= '0;
            rxc_q <= '0;
            mode_q <= ascx_pkg::MODE_RST;
        end else if (REG_WR && CLK_EN) begin
            if (REG_ADDR == ascx_pkg::REG_TX_CTRL) txc_q <= REG_WDATA;
            if (REG_ADDR == ascx_pkg::REG_RX_CTRL) rxc_q <= REG_WDATA;
            if (REG_ADDR == ascx_pkg::REG_MODE) mode_q <= REG_WDATA;
        end
    end

    // ticks since the break bit changed; the line follows at the next cell edge
    logic [6:0] brk_age_q;
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            brk_age_q <= 7'h00;
        end else if (REG_WR && CLK_EN && REG_ADDR == ascx_pkg::REG_TX_CTRL
                     && REG_WDATA[ascx_pkg::TXC_BRK] != txc_q[ascx_pkg::TXC_BRK]) begin
            brk_age_q <= 7'h00;
        end else if (CLK_EN && TRXC_EN && brk_age_q != 7'h7F) begin
            brk_age_q <= brk_age_q + 7'h01;
        end
    end

    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);

    property p_rts;
        !rxc_q[ascx_pkg::RXC_AUTO] && mode_q[5:2] != 4'h8 |-> RTS_N == !txc_q[ascx_pkg::TXC_REQ];
    endproperty
    a_rts: assert property (p_rts) else $error("request pin not inverse of bit");
    property p_brk; txc_q[ascx_pkg::TXC_BRK] && brk_age_q > 7'h40 |-> !TXD; endproperty
    a_brk: assert property (p_brk) else $error("break not holding line low");
    property p_idle;
        !txc_q[ascx_pkg::TXC_EN] && !txc_q[ascx_pkg::TXC_BRK] && brk_age_q > 7'h40 |-> TXD;
    endproperty
    a_idle: assert property (p_idle) else $error("idle line not high");
    property p_rd0; !$past(REG_RD) |-> REG_RDATA == '0; endproperty
    a_rd0: assert property (p_rd0) else $error("read data outside answer cycle");
    property p_unmap; $past(REG_RD) && $past(REG_ADDR) == 4'h2 |-> REG_RDATA == '0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped index read not zero");
    property p_cts;
        $stable(CTS_N) [*4] ##0 (REG_RD && REG_ADDR == ascx_pkg::REG_LINE_STAT)
            |=> REG_RDATA[ascx_pkg::LS_CTS] == !$past(CTS_N);
    endproperty
    a_cts: assert property (p_cts) else $error("clear-to-send status wrong");
    property p_auto;
        (CTS_N && rxc_q[ascx_pkg::RXC_AUTO] && !txc_q[ascx_pkg::TXC_BRK]) [*4] ##0 TXD |=> TXD;
    endproperty
    a_auto: assert property (p_auto) else $error("sent while clear-to-send high");
    property p_hold;
        mode_q[3:2] != 2'h0 && rxc_q[ascx_pkg::RXC_AUTO] && !txc_q[ascx_pkg::TXC_BRK] && !RTS_N && !TXD
            |=> !RTS_N;
    endproperty
    a_hold: assert property (p_hold) else $error("request dropped inside frame");

    c_brk: cover property (txc_q[ascx_pkg::TXC_BRK] && !txc_q[ascx_pkg::TXC_EN]);
    c_auto: cover property (rxc_q[ascx_pkg::RXC_AUTO] && CTS_N && TXD);
    c_cts: cover property (REG_RD && REG_ADDR == ascx_pkg::REG_LINE_STAT);
endmodule

bind ascx_channel ascx_channel_monitor #(.DW(DW)) ascx_channel_monitor_i (
    .CORE_CLK(CORE_CLK), .NRST(NRST), .CLK_EN(CLK_EN), .TRXC_EN(TRXC_EN), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .RXD(RXD),
    .TXD(TXD), .CTS_N(CTS_N), .RTS_N(RTS_N), .FLAG_LAST_ZERO(FLAG_LAST_ZERO)
);

// *** bench/tb_top.sv ***
// Purpose: self-checking bench for the async serial channel
// Assumes: x16 factor, eight bit characters, one stop bit
// Notes:   line side handled by ascx_line_model
`timescale 1ns/1ps
module tb_top;
    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       cts_n = 1'b0;
    logic       flz = 1'b0;
    logic [7:0] rdata;
    logic [7:0] d;
    logic [15:0] fr;
    logic       tick;
    logic       rxd;
    logic       txd;
    logic       rts_n;
    logic [7:0] rdv;
    int         fails = 0;
    int         tests_run = 0;
    logic [7:0] rx_tab [3] = '{8'h3C, 8'h55, 8'h5A};

    always #25 clk = !clk;

    ascx_channel ascx_channel_i (
        .CORE_CLK(clk), .NRST(nrst), .CLK_EN(1'b1), .TRXC_EN(tick), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .RXD(rxd),
        .TXD(txd), .CTS_N(cts_n), .RTS_N(rts_n), .FLAG_LAST_ZERO(flz)
    );
    ascx_line_model ascx_line_model_i (.clk(clk), .rst_n(nrst), .tick(tick), .rxd(rxd), .txd(txd));

    task automatic complete_run;
        if (fails == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        complete_run();
    end

    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rd_reg(4'h2, rdv);
        check("unmapped", rdv, 8'h00);
        wr_reg(ascx_pkg::REG_MODE, 8'h45);
        wr_reg(ascx_pkg::REG_RX_CTRL, 8'hC0);
        wr_reg(ascx_pkg::REG_TX_CTRL, 8'h60);
        wr_reg(ascx_pkg::REG_TX_CTRL, 8'h68);
        wr_reg(ascx_pkg::REG_RX_CTRL, 8'hC1);
        check("idle", txd, 1'b1);
        // both parity senses on the transmit side
        for (int p = 0; p < 2; p++) begin
            d = p ? 8'h5B : 8'hA5;
            wr_reg(ascx_pkg::REG_MODE, 8'h45 | (p << 1));
            fork
                ascx_line_model_i.get_frame(11, fr);
                wr_reg(ascx_pkg::REG_TX_DATA, d);
            join
            check("start", fr[0], 1'b0);
            check("data", fr[8:1], d);
            check("parity", fr[9], p ? ^d : ~^d);
            check("stop", fr[10], 1'b1);
            repeat (40) @(posedge clk);
            rd_reg(ascx_pkg::REG_SPEC_STAT, rdv);
            check("all sent", rdv[ascx_pkg::SS_ALL_SENT], 1'b1);
            rd_reg(ascx_pkg::REG_LINE_STAT, rdv);
            check("tx empty", rdv[ascx_pkg::LS_TX_EMPTY], 1'b1);
        end
        @(posedge clk);
        cts_n <= 1'b1;
        repeat (6) @(posedge clk);
        rd_reg(ascx_pkg::REG_LINE_STAT, rdv);
        check("cts high", rdv[ascx_pkg::LS_CTS], 1'b0);
        wr_reg(ascx_pkg::REG_TX_CTRL, 8'h6A);
        check("rts on", rts_n, 1'b0);
        wr_reg(ascx_pkg::REG_TX_CTRL, 8'h68);
        check("rts off", rts_n, 1'b1);
        wr_reg(ascx_pkg::REG_TX_CTRL, 8'h10);
        repeat (40) @(posedge clk);
        check("break", txd, 1'b0);
        wr_reg(ascx_pkg::REG_TX_CTRL, 8'h00);
        repeat (40) @(posedge clk);
        check("break end", txd, 1'b1);
        // auto enables: held by clear-to-send, request kept through the frame
        wr_reg(ascx_pkg::REG_RX_CTRL, 8'hE1);
        wr_reg(ascx_pkg::REG_TX_CTRL, 8'h6A);
        wr_reg(ascx_pkg::REG_TX_DATA, 8'h3C);
        repeat (200) @(posedge clk);
        check("cts gate", txd, 1'b1);
        fork
            ascx_line_model_i.get_frame(11, fr);
            begin
                @(posedge clk);
                cts_n <= 1'b0;
                repeat (100) @(posedge clk);
                wr_reg(ascx_pkg::REG_TX_CTRL, 8'h68);
                check("rts hold", rts_n, 1'b0);
            end
        join
        check("auto data", fr[8:1], 8'h3C);
        repeat (40) @(posedge clk);
        check("rts release", rts_n, 1'b1);
        wr_reg(ascx_pkg::REG_RX_CTRL, 8'hC1);
        // receive: clean, parity error, framing error
        for (int i = 0; i < 3; i++) begin
            d = rx_tab[i];
            ascx_line_model_i.send_frame({5'h00, i != 2, (^d) ^ (i == 1), d, 1'b0}, 11, 1'b1);
            repeat (20) @(posedge clk);
            rd_reg(ascx_pkg::REG_SPEC_STAT, rdv);
            check("par err", rdv[ascx_pkg::SS_PAR_ERR], i == 1);
            check("frm err", rdv[ascx_pkg::SS_FRM_ERR], i == 2);
            rd_reg(ascx_pkg::REG_RX_DATA, rdv);
            check("rx data", rdv, d);
            repeat (40) @(posedge clk);
        end
        ascx_line_model_i.send_frame(16'h0000, 11, 1'b0);
        repeat (40) @(posedge clk);
        rd_reg(ascx_pkg::REG_LINE_STAT, rdv);
        check("break set", rdv[ascx_pkg::LS_BREAK], 1'b1);
        rd_reg(ascx_pkg::REG_SPEC_STAT, rdv);
        check("null frm", rdv[ascx_pkg::SS_FRM_ERR], 1'b0);
        rd_reg(ascx_pkg::REG_RX_DATA, rdv);
        check("null data", rdv, 8'h00);
        ascx_line_model_i.send_frame(16'h0001, 1, 1'b1);
        repeat (40) @(posedge clk);
        rd_reg(ascx_pkg::REG_LINE_STAT, rdv);
        check("break clear", rdv[ascx_pkg::LS_BREAK], 1'b0);
        // bit-oriented auto release: request held until the closing flag ends
        wr_reg(ascx_pkg::REG_MODE, 8'h20);
        wr_reg(ascx_pkg::REG_EXT_STAT, 8'h01);
        wr_reg(ascx_pkg::REG_FLAG_EXT, 8'h04);
        wr_reg(ascx_pkg::REG_MISC, 8'h08);
        wr_reg(ascx_pkg::REG_TX_CTRL, 8'h02);
        wr_reg(ascx_pkg::REG_TX_CTRL, 8'h00);
        check("rts flag hold", rts_n, 1'b0);
        @(posedge clk);
        flz <= 1'b1;
        @(posedge clk);
        flz <= 1'b0;
        @(posedge clk);
        #1;
        check("rts flag end", rts_n, 1'b1);
        complete_run();
    end
endmodule
